// ===== rtl/pot_pkg.sv
package pot_pkg;
  // instruction byte layout
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 13;
  localparam int ADR_MSB = 12;
  localparam int ADR_LSB = 8;
  localparam logic [2:0] OP_NOP = 3'h0;
  localparam logic [2:0] OP_ACCESS_RD = 3'h1;
  localparam logic [2:0] OP_ACCESS_WR = 3'h3;
  localparam logic [2:0] OP_REG_RD = 3'h4;
  localparam logic [2:0] OP_REG_WR = 3'h6;
  localparam logic [2:0] RESP_CODE = 3'h7;
  // device register addresses and power-up values
  localparam logic [4:0] ADR_WIPER_0 = 5'h00;
  localparam logic [4:0] ADR_WIPER_1 = 5'h01;
  localparam logic [4:0] ADR_ACCESS = 5'h10;
  localparam logic [7:0] WIPER_RESET = 8'h40;
  localparam logic [7:0] WIPER_MASK = 8'h7f;
  localparam logic [7:0] ACCESS_RESET = 8'h40;
  localparam logic [7:0] ACCESS_MASK = 8'h42;
  localparam int ACCESS_SHUTDOWN_N_BIT = 6;
  localparam int ACCESS_OPEN_DRAIN_BIT = 1;
  localparam int FRAME_BITS = 16;
  // controller register map on APB
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam logic [7:0] APB_FRAMES = 8'h08;
  localparam logic [7:0] FRAMES_RESET = 8'h01;
  localparam logic [1:0] APB_TX_REGION = 2'h1;
  localparam logic [1:0] APB_RX_REGION = 2'h2;
  localparam int HALF_CYCLES = 4;
  localparam int MAX_FRAMES = 8;

  typedef enum logic [1:0] {TGT_NONE, TGT_W0, TGT_W1, TGT_ACCESS} target_t;
endpackage

// ===== rtl/pot_link_if.sv
`timescale 1ns/1ps
interface pot_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic miso;

  // undriven serial out floats high, as through a pull-up
  assign miso = miso_oe ? miso_o : 1'b1;

  modport host
  (
    output sck,
    output cs_n,
    output mosi,
    input miso
  );

  modport device
  (
    input sck,
    input cs_n,
    input mosi,
    output miso_o,
    output miso_oe
  );
endinterface

// ===== rtl/pot_sync.sv
`timescale 1ns/1ps
module pot_sync
#(
  parameter logic INIT = 1'b0
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  always_ff @(posedge clk)
  begin
    s1_ff <= rst ? INIT : din;
    s2_ff <= rst ? INIT : s1_ff;
    s3_ff <= rst ? INIT : s2_ff;
  end

  // a change counts only once the last two stages agree
  always_ff @(posedge clk)
  begin
    if (rst)
      dout <= INIT;
    else if (s2_ff == s3_ff)
      dout <= s3_ff;
  end
endmodule

// ===== rtl/pot_device.sv
// What this block and pot_host do
// (R1) access control at 10000b, wipers 00000b, 00001b
// (R2) wiper registers writable and readable back
// (R3) host chains data out to next input
// (R4) host sends farthest device frame first
// (R5) each device forwards received stream downstream
// (R6) pending write executes at chip select rise
// (R7) read part one: read frames, farthest first
// (R8) read part two: NOP frames execute reads
// (R9) odd byte 111b plus address, even data
// (R10) three-bit opcode then five address bits
// (R11) opcodes 000 001 011 100 110 decoded
// (R12) sample rising, shift falling, MSB first
// (R13) wipers power up at 40h
// (R14) output lags input sixteen clocks, act on last
// (R15) host shifts exactly N whole frames
`timescale 1ns/1ps
module pot_device
  import pot_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  pot_link_if.device LINK,
  output logic [7:0] WIPER_POSITION_0,
  output logic [7:0] WIPER_POSITION_1,
  output logic SHUTDOWN_N,
  output logic SDO_OPEN_DRAIN
);
  logic [15:0] shift_ff;
  logic started_ff;
  logic fell_ff;
  logic out_ff;
  logic sdo_bit;
  logic [15:0] resp_word;

  logic cs_hi;
  logic cs_prev_ff;
  logic exec;
  logic [7:0] wiper_position_0_ff;
  logic [7:0] wiper_position_1_ff;
  logic [7:0] access_control_ff;
  logic [15:0] resp_ff;
  logic read_pend_ff;
  logic [2:0] op;
  logic [4:0] adr;
  logic [7:0] dat;
  logic is_rd;
  logic is_wr;
  target_t tgt;
  logic [4:0] echo_adr;
  logic [7:0] rd_data;

  // ****************************************
  // decode helper
  // ****************************************
  function automatic target_t decode_target(input logic [2:0] o, input logic [4:0] a);
    target_t t;
    t = TGT_NONE;
    if (o == OP_ACCESS_RD || o == OP_ACCESS_WR) // R11
      t = TGT_ACCESS;
    else if (o == OP_REG_RD || o == OP_REG_WR)
    begin
      if (a == ADR_WIPER_0) // R1
        t = TGT_W0;
      else if (a == ADR_WIPER_1) // R1
        t = TGT_W1;
      else if (a == ADR_ACCESS) // R1
        t = TGT_ACCESS;
    end
    return t;
  endfunction

  // ****************************************
  // serial side, on the link clock
  // ****************************************
  // flags cleared while deselected so every chip select window starts clean
  always_ff @(posedge LINK.sck or posedge LINK.cs_n)
  begin
    if (LINK.cs_n)
      started_ff <= 1'b0;
    else
      started_ff <= 1'b1;
  end

  always_ff @(negedge LINK.sck or posedge LINK.cs_n)
  begin
    if (LINK.cs_n)
      fell_ff <= 1'b0;
    else
      fell_ff <= 1'b1;
  end

  // response word is quasi-static: written only while chip select is high
  assign resp_word = read_pend_ff ? resp_ff : 16'h0000;

  // first rising edge preloads the pending answer behind the new bit
  always_ff @(posedge LINK.sck)
  begin
    if (started_ff)
      shift_ff <= {shift_ff[14:0], LINK.mosi}; // R12 R14
    else
      shift_ff <= {resp_word[14:0], LINK.mosi}; // R8 R9
  end

  always_ff @(negedge LINK.sck)
  begin
    out_ff <= shift_ff[15]; // R5 R12 R14
  end

  // MSB of the answer must sit on the pin before the first rising edge
  assign sdo_bit = fell_ff ? out_ff : resp_word[15]; // R12
  assign LINK.miso_o = sdo_bit;
  assign LINK.miso_oe = !LINK.cs_n && (!access_control_ff[ACCESS_OPEN_DRAIN_BIT] || !sdo_bit);

  // ****************************************
  // chip select crossing
  // ****************************************
  pot_sync #(.INIT(1'b1)) u_cs_sync
  (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .din(LINK.cs_n),
    .dout(cs_hi)
  );

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      cs_prev_ff <= 1'b1;
    else
      cs_prev_ff <= cs_hi;
  end

  // shift word is stable here: the link clock stays idle while deselected
  assign exec = cs_hi && !cs_prev_ff; // R6
  assign op = shift_ff[OP_MSB:OP_LSB]; // R10 R14
  assign adr = shift_ff[ADR_MSB:ADR_LSB]; // R10
  assign dat = shift_ff[7:0];
  assign is_rd = (op == OP_ACCESS_RD) || (op == OP_REG_RD); // R11
  assign is_wr = (op == OP_ACCESS_WR) || (op == OP_REG_WR); // R11
  assign tgt = decode_target(op, adr);

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      wiper_position_0_ff <= WIPER_RESET; // R13
    else if (exec && is_wr && tgt == TGT_W0)
      wiper_position_0_ff <= dat & WIPER_MASK; // R2 R6
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      wiper_position_1_ff <= WIPER_RESET; // R13
    else if (exec && is_wr && tgt == TGT_W1)
      wiper_position_1_ff <= dat & WIPER_MASK; // R2 R6
  end

  // only the shutdown and open-drain bits are writable
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      access_control_ff <= ACCESS_RESET;
    else if (exec && is_wr && tgt == TGT_ACCESS)
      access_control_ff <= dat & ACCESS_MASK; // R6 R11
  end

  // ****************************************
  // read answer for the next frame
  // ****************************************
  always_comb
  begin
    unique case (tgt)
      TGT_W0: rd_data = wiper_position_0_ff; // R2
      TGT_W1: rd_data = wiper_position_1_ff; // R2
      TGT_ACCESS: rd_data = access_control_ff;
      TGT_NONE: rd_data = 8'h00;
    endcase
  end

  assign echo_adr = (op == OP_ACCESS_RD) ? ADR_ACCESS : adr;

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      resp_ff <= 16'h0000;
    else if (exec && is_rd)
      resp_ff <= {RESP_CODE, echo_adr, rd_data}; // R9
  end

  // any later frame, such as the NOP of part two, retires the answer
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      read_pend_ff <= 1'b0;
    else if (exec)
      read_pend_ff <= is_rd; // R8
  end

  // ****************************************
  // user outputs
  // ****************************************
  assign WIPER_POSITION_0 = wiper_position_0_ff;
  assign WIPER_POSITION_1 = wiper_position_1_ff;
  assign SHUTDOWN_N = access_control_ff[ACCESS_SHUTDOWN_N_BIT];
  assign SDO_OPEN_DRAIN = access_control_ff[ACCESS_OPEN_DRAIN_BIT];
endmodule

// ===== rtl/pot_host.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module pot_host
  import pot_pkg::*;
#(
  parameter int HALF = HALF_CYCLES,
  parameter int FRAMES = MAX_FRAMES
)
(
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  pot_link_if.host LINK
);
  localparam int IW = (FRAMES > 1) ? $clog2(FRAMES) : 1;
  typedef enum logic [2:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_TAIL, ST_GAP} state_t;

  logic [15:0] tx_mem [FRAMES];
  logic [15:0] rx_mem [FRAMES];
  state_t state_ff;
  logic [7:0] cnt_ff;
  logic [7:0] n_frames_ff;
  logic [IW-1:0] frame_ff;
  logic [3:0] bitpos_ff;
  logic [15:0] rx_sh_ff;
  logic done_ff;
  logic sck_ff;
  logic cs_n_ff;
  logic mosi_ff;
  logic miso_s;
  logic [31:0] prdata_ff;
  logic acc;
  logic wr;
  logic hit;
  logic [IW-1:0] idx;
  logic half_end;
  logic last_bit;
  logic go;

  // ****************************************
  // apb slave, zero wait states
  // ****************************************
  function automatic logic idx_ok(input logic [7:0] a);
    return 32'(a[5:2]) < FRAMES;
  endfunction

  assign acc = PSEL && PENABLE;
  assign idx = IW'(PADDR[5:2]);
  assign hit = (PADDR == APB_CTRL) || (PADDR == APB_STATUS) || (PADDR == APB_FRAMES)
    || ((PADDR[7:6] == APB_TX_REGION || PADDR[7:6] == APB_RX_REGION) && idx_ok(PADDR));
  assign wr = acc && PWRITE && hit;
  assign PREADY = 1'b1;
  assign PSLVERR = acc && !hit;
  assign PRDATA = prdata_ff;
  assign go = wr && PADDR == APB_CTRL && PWDATA[0] && state_ff == ST_IDLE
    && n_frames_ff != 8'h00 && 32'(n_frames_ff) <= FRAMES;

  // read data prepared in the setup cycle
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      prdata_ff <= 32'h0000_0000;
    else if (PSEL && !PENABLE)
    begin
      prdata_ff <= 32'h0000_0000;
      if (PADDR == APB_STATUS)
        prdata_ff <= {30'h0000_0000, done_ff, state_ff != ST_IDLE};
      else if (PADDR == APB_FRAMES)
        prdata_ff <= {24'h00_0000, n_frames_ff};
      else if (PADDR[7:6] == APB_TX_REGION && idx_ok(PADDR))
        prdata_ff <= {16'h0000, tx_mem[idx]};
      else if (PADDR[7:6] == APB_RX_REGION && idx_ok(PADDR))
        prdata_ff <= {16'h0000, rx_mem[idx]};
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      n_frames_ff <= FRAMES_RESET;
    else if (wr && PADDR == APB_FRAMES)
      n_frames_ff <= PWDATA[7:0];
  end

  // slot 0 leaves first, so it holds the farthest device's frame
  always_ff @(posedge REF_CLK)
  begin
    if (wr && PADDR[7:6] == APB_TX_REGION)
      tx_mem[idx] <= PWDATA[15:0]; // R4 R7
  end

  // ****************************************
  // serial engine
  // ****************************************
  pot_sync #(.INIT(1'b1)) u_miso_sync
  (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .din(LINK.miso),
    .dout(miso_s)
  );

  assign half_end = cnt_ff == 8'(HALF - 1);
  assign last_bit = bitpos_ff == 4'h0 && 8'(frame_ff) == n_frames_ff - 8'h01; // R15

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST || state_ff == ST_IDLE || half_end)
      cnt_ff <= 8'h00;
    else
      cnt_ff <= cnt_ff + 8'h01;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      state_ff <= ST_IDLE;
    else
    begin
      unique case (state_ff)
        ST_IDLE: if (go) state_ff <= ST_LOW;
        ST_LOW: if (half_end) state_ff <= ST_HIGH;
        ST_HIGH: if (half_end) state_ff <= last_bit ? ST_TAIL : ST_LOW;
        ST_TAIL: if (half_end) state_ff <= ST_GAP;
        ST_GAP: if (half_end) state_ff <= ST_IDLE;
      endcase
    end
  end

  // one chip select window carries every frame of the sequence
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      cs_n_ff <= 1'b1;
    else if (go)
      cs_n_ff <= 1'b0; // R4 R7 R8
    else if (state_ff == ST_TAIL && half_end)
      cs_n_ff <= 1'b1; // R6
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      sck_ff <= 1'b0;
    else if (state_ff == ST_LOW && half_end)
      sck_ff <= 1'b1;
    else if (state_ff == ST_HIGH && half_end)
      sck_ff <= 1'b0;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST || go)
    begin
      frame_ff <= '0;
      bitpos_ff <= 4'hf;
    end
    else if (state_ff == ST_HIGH && half_end && !last_bit)
    begin
      bitpos_ff <= bitpos_ff - 4'h1;
      if (bitpos_ff == 4'h0)
        frame_ff <= frame_ff + IW'(1);
    end
  end

  // data moves right after the falling edge, MSB first
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      mosi_ff <= 1'b0;
    else if (go)
      mosi_ff <= tx_mem[0][15];
    else if (state_ff == ST_HIGH && half_end && !last_bit)
    begin
      if (bitpos_ff == 4'h0)
        mosi_ff <= tx_mem[frame_ff + IW'(1)][15];
      else
        mosi_ff <= tx_mem[frame_ff][bitpos_ff - 4'h1];
    end
  end

  // taken as the clock falls: the synchroniser needs four cycles, so a
  // half period is too short, while the bit stands for a whole period
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      rx_sh_ff <= 16'h0000;
    else if (state_ff == ST_HIGH && half_end)
      rx_sh_ff <= {rx_sh_ff[14:0], miso_s};
  end

  always_ff @(posedge REF_CLK)
  begin
    if (state_ff == ST_HIGH && half_end && bitpos_ff == 4'h0)
      rx_mem[frame_ff] <= {rx_sh_ff[14:0], miso_s}; // R9
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST || go)
      done_ff <= 1'b0;
    else if (state_ff == ST_GAP && half_end)
      done_ff <= 1'b1;
  end

  assign LINK.sck = sck_ff; // R3
  assign LINK.cs_n = cs_n_ff; // R3
  assign LINK.mosi = mosi_ff;
endmodule

// ===== sim/pot_link_sva.sv
`timescale 1ns/1ps
module pot_link_sva
#(
  parameter int HALF = 4,
  parameter int FRAMES = 8
)
(
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso
);
  int hi_ff;
  int rise_ff;
  logic sck_d_ff;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);

  // ****************
  // helper counters
  // ****************
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST || !sck)
      hi_ff <= 0;
    else
      hi_ff <= hi_ff + 1;
  end

  // sck is made from REF_CLK, so edges are seen cleanly here
  always_ff @(posedge REF_CLK)
  begin
    sck_d_ff <= sck;
    if (SYS_RST || cs_n)
      rise_ff <= 0;
    else if (sck && !sck_d_ff)
      rise_ff <= rise_ff + 1;
  end

  // ****************
  // properties
  // ****************
  property p_oe_off;
    cs_n |-> !miso_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("serial out driven while deselected");

  property p_sck_idle;
    cs_n |-> !sck;
  endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("link clock active outside a frame window");

  property p_sck_high;
    $fell(sck) |-> hi_ff == HALF;
  endproperty
  a_sck_high: assert property (p_sck_high)
    else $error("link clock high phase of wrong length");

  property p_mosi;
    $changed(mosi) |-> !sck;
  endproperty
  a_mosi: assert property (p_mosi)
    else $error("host data changed while clock high");

  property p_frames;
    $rose(cs_n) |-> (rise_ff % 16) == 0 && rise_ff > 0 && rise_ff <= 16 * FRAMES;
  endproperty
  a_frames: assert property (p_frames)
    else $error("window not a whole number of frames");

  property p_cs_quiet;
    $rose(cs_n) |-> !sck && !$past(sck, HALF);
  endproperty
  a_cs_quiet: assert property (p_cs_quiet)
    else $error("select rose too close to clock activity");

  property p_oe_on;
    !cs_n && !miso_o |-> miso_oe;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("serial out low level not driven");

  property p_miso_chg;
    $changed(miso_o) |-> !sck;
  endproperty
  a_miso_chg: assert property (p_miso_chg)
    else $error("serial out changed while clock high");

  c_two: cover property ($rose(cs_n) && rise_ff == 32);
  c_low: cover property (!cs_n && !miso);
  c_high: cover property (!cs_n && miso && $rose(sck));
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb
  import pot_pkg::*;
;
  logic REF_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic [7:0] nw0, nw1, fw0, fw1;
  logic nsd, nod, fsd, fod;
  logic [31:0] rd;
  logic er;
  int err_count = 0;
  int total_checks = 0;
  localparam logic [15:0] RQ [6] = '{{OP_REG_RD, ADR_WIPER_0, 8'h00},
    {OP_ACCESS_RD, 5'h03, 8'h00}, {OP_REG_RD, ADR_ACCESS, 8'h00},
    {OP_REG_RD, ADR_WIPER_1, 8'h00}, {OP_REG_RD, 5'h05, 8'h00},
    {OP_REG_RD, ADR_WIPER_0, 8'h00}};
  localparam logic [15:0] RS [6] = '{{RESP_CODE, ADR_WIPER_0, 8'h15},
    {RESP_CODE, ADR_ACCESS, 8'h42}, {RESP_CODE, ADR_ACCESS, 8'h00},
    {RESP_CODE, ADR_WIPER_1, 8'h22}, {RESP_CODE, 5'h05, 8'h00},
    {RESP_CODE, ADR_WIPER_0, 8'h40}};

  always #50 REF_CLK = ~REF_CLK;

  // ****************
  // chain: host -> near -> far -> host
  // ****************
  pot_link_if link_if();
  pot_link_if near_if();
  pot_link_if far_if();
  assign near_if.sck = link_if.sck;
  assign near_if.cs_n = link_if.cs_n;
  assign near_if.mosi = link_if.mosi;
  assign far_if.sck = link_if.sck;
  assign far_if.cs_n = link_if.cs_n;
  assign far_if.mosi = near_if.miso;
  assign link_if.miso_o = far_if.miso_o;
  assign link_if.miso_oe = far_if.miso_oe;

  pot_host #(.HALF(HALF_CYCLES), .FRAMES(MAX_FRAMES)) pot_host_i (.REF_CLK(REF_CLK),
    .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .LINK(link_if));
  pot_device pot_device_i (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .LINK(near_if),
    .WIPER_POSITION_0(nw0), .WIPER_POSITION_1(nw1), .SHUTDOWN_N(nsd), .SDO_OPEN_DRAIN(nod));
  pot_device pot_device_far_i (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .LINK(far_if),
    .WIPER_POSITION_0(fw0), .WIPER_POSITION_1(fw1), .SHUTDOWN_N(fsd), .SDO_OPEN_DRAIN(fod));
  pot_link_sva #(.HALF(HALF_CYCLES), .FRAMES(MAX_FRAMES)) pot_link_sva_i (.REF_CLK(REF_CLK),
    .SYS_RST(SYS_RST), .sck(link_if.sck), .cs_n(link_if.cs_n), .mosi(link_if.mosi),
    .miso_o(link_if.miso_o), .miso_oe(link_if.miso_oe), .miso(link_if.miso));

  // ****************
  // tasks
  // ****************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic give_up();
    err_count++;
    $display("[FAIL] %0t wait ran out", $time);
    tally_and_finish();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until the edge that sees pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1 && n < 50)
    begin
      @(posedge REF_CLK);
      n++;
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (PREADY !== 1'b1)
      give_up();
  endtask

  // slot 0 travels farthest down the chain
  task automatic run2(input logic [15:0] s0, input logic [15:0] s1);
    int n = 0;
    apb(1'b1, {APB_TX_REGION, 6'h00}, {16'h0000, s0});
    apb(1'b1, {APB_TX_REGION, 6'h04}, {16'h0000, s1});
    apb(1'b1, APB_CTRL, 32'h0000_0001);
    do
    begin
      apb(1'b0, APB_STATUS, 32'h0000_0000);
      n++;
      if (n == 1)
        chk({30'h0, rd[1:0]}, 32'h0000_0001);
    end
    while (rd[1] !== 1'b1 && n < 300);
    if (rd[1] !== 1'b1)
      give_up();
    repeat (8) @(posedge REF_CLK);
  endtask

  // ****************
  // main sequence
  // ****************
  initial
  begin
    repeat (16) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    @(posedge REF_CLK);
    chk({nw0, nw1, fw0, fw1}, {4{WIPER_RESET}});
    chk({28'h0, nsd, nod, fsd, fod}, 32'h0000_000a);
    apb(1'b0, APB_FRAMES, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    apb(1'b0, 8'hfc, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    apb(1'b1, APB_FRAMES, 32'h0000_0000);
    apb(1'b1, APB_CTRL, 32'h0000_0001);
    apb(1'b0, APB_STATUS, 32'h0000_0000);
    chk({30'h0, rd[0], link_if.cs_n}, 32'h0000_0001);
    $display("test reset and refusal done");
    apb(1'b1, APB_FRAMES, 32'h0000_0002);
    run2({OP_REG_WR, ADR_WIPER_0, 8'h95}, {OP_REG_WR, ADR_WIPER_1, 8'h22});
    chk({nw0, nw1, fw0, fw1}, 32'h4022_1540);
    apb(1'b0, {APB_TX_REGION, 6'h04}, 32'h0000_0000);
    chk(rd, {16'h0000, OP_REG_WR, ADR_WIPER_1, 8'h22});
    run2({OP_ACCESS_WR, 5'h00, 8'h00}, {OP_REG_WR, ADR_ACCESS, 8'hff});
    chk({28'h0, nsd, nod, fsd, fod}, 32'h0000_000c);
    $display("test chained write done");
    for (int k = 0; k < 3; k++)
    begin
      run2(RQ[2 * k], RQ[2 * k + 1]);
      run2({OP_NOP, 5'h00, 8'h00}, {OP_NOP, 5'h00, 8'h00});
      apb(1'b0, {APB_RX_REGION, 6'h00}, 32'h0000_0000);
      chk({16'h0000, rd[15:0]}, {16'h0000, RS[2 * k]});
      apb(1'b0, {APB_RX_REGION, 6'h04}, 32'h0000_0000);
      chk({16'h0000, rd[15:0]}, {16'h0000, RS[2 * k + 1]});
    end
    chk({nw0, nw1, fw0, fw1}, 32'h4022_1540);
    $display("test chained read done");
    tally_and_finish();
  end
endmodule
